/* rtl/agu_pkg.sv */
// Shared constants and types for the effective-address unit.
// Assumes a single core clock and a 32-bit classic Wishbone slave port.
package agu_pkg;
    // Register byte offsets on the slave port
    localparam logic [4:0]  OFS_CONTROL   = 5'h00;
    localparam logic [4:0]  OFS_X_START   = 5'h04;
    localparam logic [4:0]  OFS_X_END     = 5'h08;
    localparam logic [4:0]  OFS_Y_START   = 5'h0c;
    localparam logic [4:0]  OFS_Y_END     = 5'h10;
    localparam logic [4:0]  OFS_STATUS    = 5'h14;
    // Control register fields
    localparam int          XSEL_LSB      = 0;
    localparam int          YSEL_LSB      = 4;
    localparam int          YEN_BIT       = 14;
    localparam int          XEN_BIT       = 15;
    localparam logic [15:0] CONTROL_MASK  = 16'hc0ff;
    localparam logic [3:0]  SEL_NONE      = 4'hf;
    // Reset values; start bit 0 reads 0, end bit 0 reads 1
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] START_RESET   = 16'h0000;
    localparam logic [15:0] END_RESET     = 16'h0001;
    // Status register fields
    localparam int          ST_WRAP_BIT   = 16;
    localparam int          ST_ERR_BIT    = 17;
    // Direct address field of file-register instructions
    localparam int          FILE_ADDR_W   = 13;
    // Fixed working registers
    localparam logic [3:0]  DEFAULT_WORKING_REG_ZERO     = 4'h0;
    localparam logic [3:0]  X_PTR_A       = 4'h8;
    localparam logic [3:0]  X_PTR_B       = 4'h9;
    localparam logic [3:0]  Y_PTR_A       = 4'ha;
    localparam logic [3:0]  Y_PTR_B       = 4'hb;
    // Legal post-modify steps of the prefetch path
    localparam logic [15:0] MAC_STEP_2    = 16'h0002;
    localparam logic [15:0] MAC_STEP_4    = 16'h0004;
    localparam logic [15:0] MAC_STEP_6    = 16'h0006;

    typedef enum logic [2:0] {
        MODE_FILE, MODE_DIRECT, MODE_INDIRECT, MODE_POST, MODE_PRE,
        MODE_REG_OFS, MODE_LIT_OFS
    } mode_type;

    typedef enum logic [2:0] {
        LIT_5, LIT_S5, LIT_10, LIT_8, LIT_16, LIT_BRANCH, LIT_COUNT
    } lit_type;

    typedef enum logic [1:0] {GEN_X_READ, GEN_X_WRITE, GEN_Y} gen_type;
endpackage

/* rtl/ea_agu.sv */
// Effective-address generation with circular-buffer correction.
// Assumes a decoder that presents one request per cycle and a classic
// Wishbone master for the buffer and control registers.
// What this block does
// - File-register direct takes a 13-bit field, reaching the lowest 8192 bytes.
// - File-register ops imply working register zero; result to file or zero, a multiply's to REQ_DST.
// - Post-modify: address is the pointer, then pointer steps by a constant.
// - Pre-modify: pointer steps by a signed constant first, giving the address.
// - Indexed: address is pointer plus offset register.
// - Literal offset: address is pointer plus instruction literal.
// - First operand always a working register; literals of 5 or 10 bits.
// - Moves add indexed and literal offset modes, 8 and 16-bit literals.
// - Source and destination share one 4-bit offset-register field.
// - Prefetch pointers 8..11; 8,9 go to X read, 10,11 to Y.
// - Prefetch indexing only with register 9 in X, 11 in Y.
// - Prefetch allows indirect, indexed, post-modify by 2, 4 or 6.
// - Branch literal is 16-bit signed; interrupt-disable count 14-bit unsigned.
// - One circular buffer in X, one in Y, usable with any pointer but 15.
// - Buffers wrap one way; power-of-two lengths check both boundaries.
// - Four 16-bit start/end registers; length is their difference plus one.
// - Buffers may be up to 32K words, 64 Kbytes long.
// - Y circular address calculation is word sized, bit 0 clear.
// - X select in control bits 3:0, enable at bit 15.
// - Y select in control bits 7:4, enable at bit 14.
// - Boundary test is beyond, not equal, so jumps are corrected.
// - Corrected value written back only for pre and post modify.
`timescale 1ns/100ps
module ea_agu (
    input  wire logic             MCLK,
    input  wire logic             SRST,
    // Wishbone slave
    input  wire logic             CYC_I,
    input  wire logic             STB_I,
    input  wire logic             WE_I,
    input  wire logic [4:0]       ADR_I,
    input  wire logic [3:0]       SEL_I,
    input  wire logic [31:0]      DAT_I,
    output      logic [31:0]      DAT_O,
    output      logic             ACK_O,
    // Working register write port from the core
    input  wire logic             W_WE,
    input  wire logic [3:0]       W_IDX,
    input  wire logic [15:0]      W_DATA,
    // Address request from the decoder
    input  wire logic             REQ_VALID,
    input  wire agu_pkg::mode_type REQ_MODE,
    input  wire agu_pkg::gen_type REQ_GEN,
    input  wire logic             REQ_MAC,
    input  wire logic             REQ_INCR,
    input  wire logic [3:0]       REQ_PTR,
    input  wire logic [3:0]       REQ_OFS,
    input  wire logic [15:0]      REQ_FIELD,
    input  wire agu_pkg::lit_type REQ_LIT_KIND,
    input  wire logic             REQ_TO_FILE,
    input  wire logic             REQ_MUL,
    input  wire logic [3:0]       REQ_DST,
    // Results
    output      logic             EA_VALID,
    output      logic [15:0]      EA,
    output      agu_pkg::gen_type EA_GEN,
    output      logic [15:0]      OPERAND,
    output      logic [15:0]      OPERAND1,
    output      logic             RESULT_TO_FILE,
    output      logic [3:0]       RESULT_REG,
    output      logic             PTR_WB,
    output      logic             ERR
);
    logic [15:0]      working_reg [16];
    logic [15:0]      control;
    logic [15:0]      x_start;
    logic [15:0]      x_end;
    logic [15:0]      y_start;
    logic [15:0]      y_end;
    logic             last_wrap;
    logic             last_err;
    logic             wb_take;
    logic [15:0]      ptr_val;
    logic [15:0]      lit;
    agu_pkg::gen_type gen;
    logic             mac_bad;
    logic             x_on;
    logic             y_on;
    logic             mod_on;
    logic [15:0]      raw_ea;
    logic [15:0]      stepped;
    logic             wb_mode;
    logic [15:0]      next_ea;
    modulo_if         mif ();

    // Literal widths by kind; only the low field bits count
    function automatic logic [15:0] lit_value(input logic [15:0] f,
                                              input agu_pkg::lit_type k);
        case (k)
            agu_pkg::LIT_5:     lit_value = {11'h0, f[4:0]};
            agu_pkg::LIT_S5:    lit_value = {{11{f[4]}}, f[4:0]};
            agu_pkg::LIT_10:    lit_value = {6'h0, f[9:0]};
            agu_pkg::LIT_8:     lit_value = {8'h0, f[7:0]};
            agu_pkg::LIT_COUNT: lit_value = {2'h0, f[13:0]};
            default:            lit_value = f;
        endcase
    endfunction

    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
        merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    assign wb_take = CYC_I && STB_I && !ACK_O;

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ACK_O <= 1'b0;
        end else begin
            ACK_O <= wb_take;
        end
    end

    // Read data captured with the ack; unmapped offsets read zero
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            DAT_O <= 32'h0;
        end else if (wb_take && !WE_I) begin
            case (ADR_I)
                agu_pkg::OFS_CONTROL: DAT_O <= {16'h0, control};
                agu_pkg::OFS_X_START: DAT_O <= {16'h0, x_start};
                agu_pkg::OFS_X_END:   DAT_O <= {16'h0, x_end};
                agu_pkg::OFS_Y_START: DAT_O <= {16'h0, y_start};
                agu_pkg::OFS_Y_END:   DAT_O <= {16'h0, y_end};
                agu_pkg::OFS_STATUS:  DAT_O <= {14'h0, last_err, last_wrap, EA};
                default:              DAT_O <= 32'h0;
            endcase
        end
    end

    // Control and boundary registers; bit 0 of start/end is fixed
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            control <= agu_pkg::CONTROL_RESET;
            x_start <= agu_pkg::START_RESET;
            x_end   <= agu_pkg::END_RESET;
            y_start <= agu_pkg::START_RESET;
            y_end   <= agu_pkg::END_RESET;
        end else if (wb_take && WE_I) begin
            case (ADR_I)
                agu_pkg::OFS_CONTROL:
                    control <= merge(control, DAT_I, SEL_I) & agu_pkg::CONTROL_MASK;
                agu_pkg::OFS_X_START:
                    x_start <= merge(x_start, DAT_I, SEL_I) & 16'hfffe;
                agu_pkg::OFS_X_END:
                    x_end   <= merge(x_end, DAT_I, SEL_I) | 16'h0001;
                agu_pkg::OFS_Y_START:
                    y_start <= merge(y_start, DAT_I, SEL_I) & 16'hfffe;
                agu_pkg::OFS_Y_END:
                    y_end   <= merge(y_end, DAT_I, SEL_I) | 16'h0001;
                default: ;
            endcase
        end
    end

    assign ptr_val = working_reg[REQ_PTR];
    assign lit     = lit_value(REQ_FIELD, REQ_LIT_KIND);

    // Prefetch pointers pick their generator by register number
    always_comb begin
        gen = REQ_GEN;
        if (REQ_MAC) begin
            gen = (REQ_PTR == agu_pkg::X_PTR_A || REQ_PTR == agu_pkg::X_PTR_B)
                  ? agu_pkg::GEN_X_READ : agu_pkg::GEN_Y;
        end
    end

    // Prefetch requests outside the reduced mode set are refused
    always_comb begin
        mac_bad = 1'b0;
        if (REQ_MAC) begin
            if (REQ_PTR < agu_pkg::X_PTR_A || REQ_PTR > agu_pkg::Y_PTR_B) begin
                mac_bad = 1'b1;
            end
            if (REQ_MODE == agu_pkg::MODE_REG_OFS &&
                REQ_PTR != agu_pkg::X_PTR_B && REQ_PTR != agu_pkg::Y_PTR_B) begin
                mac_bad = 1'b1;
            end
            if (REQ_MODE != agu_pkg::MODE_INDIRECT &&
                REQ_MODE != agu_pkg::MODE_POST &&
                REQ_MODE != agu_pkg::MODE_REG_OFS) begin
                mac_bad = 1'b1;
            end
            if (REQ_MODE == agu_pkg::MODE_POST && lit != agu_pkg::MAC_STEP_2 &&
                lit != agu_pkg::MAC_STEP_4 && lit != agu_pkg::MAC_STEP_6) begin
                mac_bad = 1'b1;
            end
        end
    end

    // Space enable: matching select, not 15, and enable bit set
    assign x_on = control[agu_pkg::XEN_BIT] &&
        control[agu_pkg::XSEL_LSB +: 4] != agu_pkg::SEL_NONE &&
        control[agu_pkg::XSEL_LSB +: 4] == REQ_PTR;
    assign y_on = control[agu_pkg::YEN_BIT] &&
        control[agu_pkg::YSEL_LSB +: 4] != agu_pkg::SEL_NONE &&
        control[agu_pkg::YSEL_LSB +: 4] == REQ_PTR;
    assign mod_on = REQ_MODE != agu_pkg::MODE_FILE &&
                    REQ_MODE != agu_pkg::MODE_DIRECT &&
                    ((gen == agu_pkg::GEN_Y) ? y_on : x_on);

    assign stepped = ptr_val + lit;
    assign wb_mode = REQ_MODE == agu_pkg::MODE_POST ||
                     REQ_MODE == agu_pkg::MODE_PRE;

    // Uncorrected address; post-modify corrects the stepped pointer
    always_comb begin
        case (REQ_MODE)
            agu_pkg::MODE_FILE:
                raw_ea = {{(16 - agu_pkg::FILE_ADDR_W){1'b0}},
                          REQ_FIELD[agu_pkg::FILE_ADDR_W-1:0]};
            agu_pkg::MODE_POST:    raw_ea = stepped;
            agu_pkg::MODE_PRE:     raw_ea = stepped;
            agu_pkg::MODE_REG_OFS:
                raw_ea = ptr_val + working_reg[REQ_OFS];
            agu_pkg::MODE_LIT_OFS: raw_ea = stepped;
            default:               raw_ea = ptr_val;
        endcase
    end

    assign mif.addr       = raw_ea;
    assign mif.start_addr = (gen == agu_pkg::GEN_Y) ? y_start : x_start;
    assign mif.end_addr   = (gen == agu_pkg::GEN_Y) ? y_end : x_end;
    assign mif.active     = mod_on;
    assign mif.incr       = REQ_INCR;
    assign mif.word_only  = gen == agu_pkg::GEN_Y;

    modulo_corrector u_corrector (
        .mif (mif.corrector)
    );

    // Post-modify hands out the pointer as it was
    assign next_ea = (REQ_MODE == agu_pkg::MODE_POST) ? ptr_val
                                                      : mif.corrected;

    // Working registers; the pointer update wins over a core write
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            for (int i = 0; i < 16; i++) begin
                working_reg[i] <= 16'h0;
            end
        end else if (REQ_VALID && !mac_bad && wb_mode) begin
            working_reg[REQ_PTR] <= mif.corrected;
        end else if (W_WE) begin
            working_reg[W_IDX] <= W_DATA;
        end
    end

    // Result pulses of one request, one cycle later
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            EA_VALID <= 1'b0;
            ERR      <= 1'b0;
            PTR_WB   <= 1'b0;
        end else begin
            EA_VALID <= REQ_VALID && !mac_bad;
            ERR      <= REQ_VALID && mac_bad;
            PTR_WB   <= REQ_VALID && !mac_bad && wb_mode;
        end
    end

    // Address, operands and destination held until the next request
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            EA             <= 16'h0;
            EA_GEN         <= agu_pkg::GEN_X_READ;
            OPERAND        <= 16'h0;
            OPERAND1       <= 16'h0;
            RESULT_TO_FILE <= 1'b0;
            RESULT_REG     <= agu_pkg::DEFAULT_WORKING_REG_ZERO;
            last_wrap      <= 1'b0;
            last_err       <= 1'b0;
        end else if (REQ_VALID) begin
            EA             <= next_ea;
            EA_GEN         <= gen;
            OPERAND        <= (REQ_MODE == agu_pkg::MODE_DIRECT) ? ptr_val : lit;
            OPERAND1       <= working_reg[REQ_OFS];
            RESULT_TO_FILE <= REQ_TO_FILE && !REQ_MUL;
            RESULT_REG     <= REQ_MUL ? REQ_DST : agu_pkg::DEFAULT_WORKING_REG_ZERO;
            last_wrap      <= mif.wrapped && !mac_bad;
            last_err       <= mac_bad;
        end
    end

    // Checks
    sequence req_post_s;
        REQ_VALID && !mac_bad && REQ_MODE == agu_pkg::MODE_POST;
    endsequence
    sequence req_index_s;
        REQ_VALID && REQ_MODE == agu_pkg::MODE_REG_OFS;
    endsequence

    bus_ack_a: assert property (@(posedge MCLK) disable iff (SRST)
        ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    file_addr_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && REQ_MODE == agu_pkg::MODE_FILE
        |=> EA_VALID && EA == {3'h0, $past(REQ_FIELD[12:0])})
        else $error("file address not taken from 13-bit field");
    post_ea_a: assert property (@(posedge MCLK) disable iff (SRST)
        req_post_s |=> EA == $past(ptr_val) && PTR_WB)
        else $error("post-modify address is not the old pointer");
    pre_ea_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && !mac_bad && REQ_MODE == agu_pkg::MODE_PRE && !mod_on
        |=> EA == $past(stepped) && working_reg[$past(REQ_PTR)] == EA)
        else $error("pre-modify address or pointer wrong");
    index_wb_a: assert property (@(posedge MCLK) disable iff (SRST)
        req_index_s |=> !PTR_WB)
        else $error("indexed access updated its pointer");
    mac_route_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && REQ_MAC && !mac_bad && REQ_PTR >= agu_pkg::Y_PTR_A
        |=> EA_GEN == agu_pkg::GEN_Y)
        else $error("prefetch pointer routed to wrong generator");
    mac_index_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && REQ_MODE == agu_pkg::MODE_REG_OFS &&
        REQ_MAC && REQ_PTR == agu_pkg::X_PTR_A
        |=> ERR && !EA_VALID)
        else $error("illegal prefetch indexing accepted");
    y_word_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && !mac_bad && gen == agu_pkg::GEN_Y && mod_on &&
        REQ_MODE != agu_pkg::MODE_POST |=> !EA[0])
        else $error("Y circular address has bit 0 set");
    sel_off_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && gen != agu_pkg::GEN_Y &&
        control[3:0] == agu_pkg::SEL_NONE |=> !last_wrap)
        else $error("X correction with select field 15");
    wrap_a: assert property (@(posedge MCLK) disable iff (SRST)
        REQ_VALID && !mac_bad && mod_on && REQ_INCR &&
        REQ_MODE == agu_pkg::MODE_PRE && raw_ea > mif.end_addr
        |=> EA == $past(raw_ea - mif.end_addr - 16'h1 + mif.start_addr))
        else $error("incrementing wrap not start plus overshoot");
endmodule // ea_agu

/* rtl/modulo_corrector.sv */
// Circular-buffer correction of one address against one start/end pair.
// Assumes the requester says direction and whether the buffer applies.
`timescale 1ns/100ps
module modulo_corrector (
    modulo_if.corrector mif
);
    logic [16:0] buf_len;
    logic [16:0] len_less;
    logic        pow2;
    logic        over_hi;
    logic        under_lo;
    logic [15:0] fixed;

    // Length follows from the boundaries; 17 bits hold a full 64 Kbytes
    assign buf_len  = {1'b0, mif.end_addr} - {1'b0, mif.start_addr} + 17'h1;
    assign len_less = buf_len - 17'h1;
    assign pow2     = (buf_len & len_less) == 17'h0;
    // Beyond, not equal: a jump past the boundary is still caught
    assign over_hi  = mif.addr > mif.end_addr;
    assign under_lo = mif.addr < mif.start_addr;

    // One direction checked, both for power-of-two lengths
    always_comb begin
        fixed       = mif.addr;
        mif.wrapped = 1'b0;
        if (mif.active && (mif.incr || pow2) && over_hi) begin
            fixed       = mif.addr - buf_len[15:0];
            mif.wrapped = 1'b1;
        end else if (mif.active && (!mif.incr || pow2) && under_lo) begin
            fixed       = mif.addr + buf_len[15:0];
            mif.wrapped = 1'b1;
        end
    end

    // Word-only space keeps bit 0 clear while the buffer is active
    assign mif.corrected = {fixed[15:1],
                            fixed[0] & !(mif.active && mif.word_only)};
endmodule // modulo_corrector

/* rtl/modulo_if.sv */
// Carrier between the address unit and its circular-buffer corrector.
// Purely combinational signals; the owner samples results itself.
`timescale 1ns/100ps
interface modulo_if;
    logic [15:0] addr;
    logic [15:0] start_addr;
    logic [15:0] end_addr;
    logic        active;
    logic        incr;
    logic        word_only;
    logic [15:0] corrected;
    logic        wrapped;

    modport requester (
        output addr, start_addr, end_addr, active, incr, word_only,
        input  corrected, wrapped
    );
    modport corrector (
        input  addr, start_addr, end_addr, active, incr, word_only,
        output corrected, wrapped
    );
endinterface // modulo_if

/* testbench/agu_decoder_model.sv */
// Decoder model: raises one address request per call of issue.
// Assumes the address unit takes a request at the next rising edge.
`timescale 1ns/100ps
module agu_decoder_model (
    input  wire logic         clk,
    output logic              valid,
    output agu_pkg::mode_type mode,
    output agu_pkg::gen_type  gen,
    output logic              mac,
    output logic [3:0]        ptr,
    output logic [3:0]        ofs,
    output logic [15:0]       field,
    output agu_pkg::lit_type  kind
);
    // Idle request at time zero
    initial begin
        valid = 1'b0;
        mode = agu_pkg::MODE_FILE;
        gen = agu_pkg::GEN_X_READ;
        mac = 1'b0;
        ptr = 4'h0;
        ofs = 4'h0;
        field = 16'h0000;
        kind = agu_pkg::LIT_16;
    end

    // Circular pointers chosen by callers are never 14 or 15
    task automatic issue(input agu_pkg::mode_type m, input logic c,
        input logic [3:0] p, input logic [3:0] o, input logic [15:0] f,
        input agu_pkg::lit_type k);
        @(posedge clk);
        valid <= 1'b1;
        mode <= m;
        mac <= c;
        ptr <= p;
        ofs <= o;
        field <= f;
        kind <= k;
        @(posedge clk);
        valid <= 1'b0;
        field <= ~f; // Stale literal is not left looking valid
        #1;
    endtask
endmodule // agu_decoder_model

/* testbench/effective_address_modulo_agu_bench.sv */
// Self-checking bench for the effective-address unit.
// Assumes one-cycle Wishbone acks and one-cycle request answers.
`timescale 1ns/100ps
module effective_address_modulo_agu_bench;
    logic MCLK = 1'b0, SRST = 1'b1, CYC_I = 1'b0, STB_I = 1'b0;
    logic WE_I = 1'b0, W_WE = 1'b0, ACK_O, EA_VALID, PTR_WB, ERR;
    logic REQ_VALID, REQ_MAC, RESULT_TO_FILE;
    logic [4:0] ADR_I = 5'h00;
    logic [3:0] W_IDX = 4'h0, REQ_PTR, REQ_OFS, RESULT_REG;
    logic [31:0] DAT_I = 32'h0, DAT_O;
    logic [15:0] W_DATA = 16'h0, REQ_FIELD, EA, OPERAND, OPERAND1;
    agu_pkg::mode_type REQ_MODE;
    agu_pkg::gen_type REQ_GEN, EA_GEN;
    agu_pkg::lit_type REQ_LIT_KIND;
    int failures = 0, n_checks = 0, cycles = 0;
    logic [15:0] lv [7] = '{16'h001f, 16'hffff, 16'h03ff, 16'h00ff,
                            16'hffff, 16'hffff, 16'h3fff};

    always #2 MCLK = ~MCLK;

    ea_agu i_ea_agu (.MCLK, .SRST, .CYC_I, .STB_I, .WE_I, .ADR_I,
        .SEL_I(4'h3), .DAT_I, .DAT_O, .ACK_O, .W_WE, .W_IDX, .W_DATA,
        .REQ_VALID, .REQ_MODE, .REQ_GEN, .REQ_MAC, .REQ_INCR(1'b1), .REQ_PTR,
        .REQ_OFS, .REQ_FIELD, .REQ_LIT_KIND, .REQ_TO_FILE(1'b1),
        .REQ_MUL(1'b0), .REQ_DST(4'h3), .EA_VALID, .EA, .EA_GEN, .OPERAND,
        .OPERAND1, .RESULT_TO_FILE, .RESULT_REG, .PTR_WB, .ERR);

    agu_decoder_model i_agu_decoder_model (.clk(MCLK), .valid(REQ_VALID),
        .mode(REQ_MODE), .gen(REQ_GEN), .mac(REQ_MAC), .ptr(REQ_PTR),
        .ofs(REQ_OFS), .field(REQ_FIELD), .kind(REQ_LIT_KIND));

    task automatic test_done();
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Values and flags are compared separately
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: value %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: flag %b want %b", $time, got, exp);
        end
    endtask

    // Classic Wishbone cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [4:0] a,
        input logic [15:0] d, output logic [31:0] q);
        @(posedge MCLK);
        CYC_I <= 1'b1;
        STB_I <= 1'b1;
        WE_I <= w;
        ADR_I <= a;
        DAT_I <= {16'h0, d};
        do @(posedge MCLK); while (ACK_O !== 1'b1);
        q = DAT_O;
        CYC_I <= 1'b0;
        STB_I <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 16'h0, q);
        chk(q, exp);
    endtask
    task automatic default_working_reg(input logic [3:0] i, input logic [15:0] d);
        @(posedge MCLK);
        W_WE <= 1'b1;
        W_IDX <= i;
        W_DATA <= d;
        @(posedge MCLK);
        W_WE <= 1'b0;
    endtask

    // One request and its answer; errors carry no address
    task automatic rq(input agu_pkg::mode_type m, input logic c,
        input logic [3:0] p, input logic [3:0] o, input logic [15:0] f,
        input agu_pkg::lit_type k, input logic [15:0] ea, input logic wbk,
        input logic er);
        i_agu_decoder_model.issue(m, c, p, o, f, k);
        chk1(EA_VALID, !er);
        chk1(ERR, er);
        chk1(PTR_WB, wbk);
        if (!er) chk({16'h0, EA}, {16'h0, ea});
    endtask

    // Hang guard well beyond the expected run length
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        repeat (5) @(posedge MCLK);
        SRST <= 1'b0;
        rd(5'h00, 32'h0);
        rd(5'h08, 32'h1);
        rd(5'h18, 32'h0);
        wr(5'h00, 16'hffff);
        rd(5'h00, 32'hc0ff);
        wr(5'h00, 16'h0000);
        default_working_reg(4'h8, 16'h1000);
        default_working_reg(4'h9, 16'h0010);
        rq(agu_pkg::MODE_POST, 0, 8, 0, 2, agu_pkg::LIT_16, 16'h1000, 1, 0);
        rq(agu_pkg::MODE_INDIRECT, 0, 8, 0, 0, agu_pkg::LIT_16, 16'h1002, 0, 0);
        rq(agu_pkg::MODE_PRE, 0, 8, 0, 16'h1e, agu_pkg::LIT_S5, 16'h1000, 1, 0);
        rq(agu_pkg::MODE_REG_OFS, 0, 8, 9, 0, agu_pkg::LIT_16, 16'h1010, 0, 0);
        rq(agu_pkg::MODE_DIRECT, 0, 8, 9, 0, agu_pkg::LIT_16, 16'h1000, 0, 0);
        chk(OPERAND1, 16'h0010);
        for (int i = 0; i < 7; i++) begin
            rq(agu_pkg::MODE_LIT_OFS, 0, 8, 0, 16'hffff,
               agu_pkg::lit_type'(i), 16'h1000 + lv[i], 0, 0);
            chk(OPERAND, lv[i]);
        end
        rq(agu_pkg::MODE_FILE, 0, 0, 0, 16'hffff, agu_pkg::LIT_16, 16'h1fff, 0, 0);
        chk({RESULT_TO_FILE, RESULT_REG}, 5'h10);
        rq(agu_pkg::MODE_REG_OFS, 1, 8, 9, 0, agu_pkg::LIT_16, 0, 0, 1);
        rq(agu_pkg::MODE_INDIRECT, 1, 12, 0, 0, agu_pkg::LIT_16, 0, 0, 1);
        rq(agu_pkg::MODE_POST, 1, 10, 0, 3, agu_pkg::LIT_16, 0, 0, 1);
        rq(agu_pkg::MODE_POST, 1, 10, 0, 4, agu_pkg::LIT_16, 0, 1, 0);
        chk(EA_GEN, agu_pkg::GEN_Y);
        wr(5'h00, 16'h80f8);
        wr(5'h04, 16'h1000);
        wr(5'h08, 16'h1007);
        default_working_reg(4'h8, 16'h1006);
        rq(agu_pkg::MODE_POST, 0, 8, 0, 4, agu_pkg::LIT_16, 16'h1006, 1, 0);
        rq(agu_pkg::MODE_INDIRECT, 0, 8, 0, 0, agu_pkg::LIT_16, 16'h1002, 0, 0);
        default_working_reg(4'h9, 16'h0006);
        rq(agu_pkg::MODE_REG_OFS, 0, 8, 9, 0, agu_pkg::LIT_16, 16'h1000, 0, 0);
        rq(agu_pkg::MODE_PRE, 0, 8, 0, 16'hfffc, agu_pkg::LIT_16, 16'h1006, 1, 0);
        wr(5'h00, 16'h80ff);
        rq(agu_pkg::MODE_PRE, 0, 8, 0, 4, agu_pkg::LIT_16, 16'h100a, 1, 0);
        rd(5'h14, 32'h0000100a);
        wr(5'h00, 16'h40af);
        wr(5'h0c, 16'h2000);
        wr(5'h10, 16'h2007);
        default_working_reg(4'ha, 16'h2007);
        rq(agu_pkg::MODE_INDIRECT, 1, 10, 0, 0, agu_pkg::LIT_16, 16'h2006, 0, 0);
        default_working_reg(4'ha, 16'h2006);
        rq(agu_pkg::MODE_POST, 1, 10, 0, 4, agu_pkg::LIT_16, 16'h2006, 1, 0);
        rq(agu_pkg::MODE_INDIRECT, 1, 10, 0, 0, agu_pkg::LIT_16, 16'h2002, 0, 0);
        test_done();
    end
endmodule // effective_address_modulo_agu_bench
